// *** pkg/epw_consts.svh ***
// timing and layout constants for the page write port host
`ifndef EPW_CONSTS_SVH
`define EPW_CONSTS_SVH

`define EPW_CLK_NS          50
`define EPW_CEIL(t_ns)      (((t_ns) + `EPW_CLK_NS - 1) / `EPW_CLK_NS)
`define EPW_FLOOR(t_ns)     ((t_ns) / `EPW_CLK_NS)

`define EPW_ADDR_W          15
`define EPW_PAGE_W          6
`define EPW_PAGE_BYTES      64
`define EPW_POLL_BIT        7
`define EPW_SYNC_CYC        2

`define EPW_T_WP_NS         250
`define EPW_T_ACC_NS        350
`define EPW_T_DF_NS         90
`define EPW_T_BLC_MIN_NS    550
`define EPW_T_BLC_MAX_US    30
`define EPW_T_BL_US         100
`define EPW_T_DW_NS         250
`define EPW_T_WC_MS         15

`define EPW_WP_CYC          `EPW_CEIL(`EPW_T_WP_NS)
`define EPW_RD_CYC          (`EPW_CEIL(`EPW_T_ACC_NS) + `EPW_SYNC_CYC + 1)
`define EPW_DF_CYC          `EPW_CEIL(`EPW_T_DF_NS)
`define EPW_BLC_MIN_CYC     `EPW_CEIL(`EPW_T_BLC_MIN_NS)
`define EPW_BLC_MAX_CYC     `EPW_FLOOR(`EPW_T_BLC_MAX_US * 1000)
`define EPW_HOLD_CYC        (`EPW_BLC_MIN_CYC - `EPW_WP_CYC - 2)
`define EPW_BL_CYC          `EPW_CEIL(`EPW_T_BL_US * 1000)
`define EPW_DW_CYC          `EPW_CEIL(`EPW_T_DW_NS)
`define EPW_WC_CYC          `EPW_FLOOR(`EPW_T_WC_MS * 1000000)

`endif

// *** pkg/epw_pkg.sv ***
// types shared by the page write port host
package epw_pkg;
  typedef logic [14:0] epw_addr_t;
  typedef logic [7:0]  epw_byte_t;
  typedef logic [5:0]  epw_idx_t;
  typedef logic [18:0] epw_cnt_t;

  typedef enum logic [3:0] {
    EPW_IDLE, EPW_RD, EPW_RD_FLOAT, EPW_FETCH, EPW_SETUP, EPW_PULSE, EPW_HOLD,
    EPW_BL, EPW_DW, EPW_POLL, EPW_POLL_GAP, EPW_FIXED
  } epw_state_t;
endpackage

// *** pkg/epw_buf_if.sv ***
// page buffer port between controller and buffer memory
interface epw_buf_if;
  logic               we;
  epw_pkg::epw_idx_t  waddr;
  epw_pkg::epw_byte_t wdata;
  epw_pkg::epw_idx_t  raddr;
  epw_pkg::epw_byte_t rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** hdl/epw_page_buf.sv ***
// page buffer: one page of bytes, registered read
`include "epw_consts.svh"
module epw_page_buf (
  // clock
  input wire logic core_clk_i,
  // buffer port
  epw_buf_if.mem   bp
);
  import epw_pkg::*;

  epw_byte_t mem_r [`EPW_PAGE_BYTES];

  always_ff @(posedge core_clk_i) begin
    if (bp.we) begin
      mem_r[bp.waddr] <= bp.wdata;
    end
    bp.rdata <= mem_r[bp.raddr];
  end
endmodule

// *** hdl/epw_ctrl.sv ***
// host controller driving a byte-wide page-write eeprom
`include "epw_consts.svh"
module epw_ctrl #(
  parameter int WC_CYC = `EPW_WC_CYC
) (
  // clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               reset_i,
  // user request
  input  wire logic               req_valid_i,
  input  wire logic               req_write_i,
  input  wire epw_pkg::epw_addr_t req_addr_i,
  input  wire epw_pkg::epw_idx_t  req_last_i,
  input  wire logic               poll_mode_i,
  output logic                    req_ready_o,
  // page buffer fill
  input  wire logic               buf_wr_i,
  input  wire epw_pkg::epw_idx_t  buf_idx_i,
  input  wire epw_pkg::epw_byte_t buf_data_i,
  // user answers
  output logic                    rd_valid_o,
  output epw_pkg::epw_byte_t      rd_data_o,
  output logic                    wr_done_o,
  output logic                    wr_timeout_o,
  // memory pins
  output epw_pkg::epw_addr_t      byte_address_o,
  input  wire epw_pkg::epw_byte_t data_bus_i,
  output epw_pkg::epw_byte_t      data_bus_o,
  output logic                    data_bus_oe_n_o,
  output logic                    ce_n_o,
  output logic                    oe_n_o,
  output logic                    we_n_o,
  output logic                    access_block_n_o,
  input  wire logic               rdy_busy_i
);
  import epw_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state
  epw_state_t state_r, state_nxt;
  epw_cnt_t   cnt_r, cnt_nxt, prog_cnt_r;
  epw_idx_t   idx_r, last_r;
  epw_addr_t  base_r;
  logic       poll_r, bit7_r, ok_r;
  epw_byte_t  din_s1_r, din_s2_r;
  logic       rb_s1_r, rb_s2_r;

  epw_buf_if u_bif ();

  epw_page_buf u_buf (
    .core_clk_i (core_clk_i),
    .bp         (u_bif.mem)
  );

  assign u_bif.we    = buf_wr_i;
  assign u_bif.waddr = buf_idx_i;
  assign u_bif.wdata = buf_data_i;
  assign u_bif.raddr = idx_r;

  ////////////////////////////////////////////////////////////////////////////////
  // decode
  wire cnt_zero  = (cnt_r == '0);
  wire take      = (state_r == EPW_IDLE) && req_valid_i;
  wire last_byte = (idx_r == last_r);
  // a poll passes only when the true bit seven reads back and the busy pin has let go
  wire poll_ok   = (din_s2_r[`EPW_POLL_BIT] == bit7_r) && rb_s2_r;
  wire timed_out = (prog_cnt_r >= epw_cnt_t'(WC_CYC - 1));
  wire fin       = ((state_r == EPW_POLL_GAP) && cnt_zero && (ok_r || timed_out)) ||
                   ((state_r == EPW_FIXED) && timed_out);
  wire in_prog   = state_r inside {EPW_DW, EPW_POLL, EPW_POLL_GAP, EPW_FIXED};

  wire ce_n_nxt  = !(state_nxt inside {EPW_RD, EPW_SETUP, EPW_PULSE, EPW_POLL});
  wire oe_n_nxt  = !(state_nxt inside {EPW_RD, EPW_POLL});
  wire we_n_nxt  = (state_nxt != EPW_PULSE);
  wire doe_n_nxt = !(state_nxt inside {EPW_PULSE, EPW_HOLD});

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_zero ? cnt_r : cnt_r - 1'b1;
    unique case (state_r)
      EPW_IDLE: if (req_valid_i) begin
        state_nxt = req_write_i ? EPW_FETCH : EPW_RD;
        cnt_nxt   = epw_cnt_t'(`EPW_RD_CYC - 1);
      end
      EPW_RD: if (cnt_zero) begin
        state_nxt = EPW_RD_FLOAT;
        cnt_nxt   = epw_cnt_t'(`EPW_DF_CYC - 1);
      end
      EPW_RD_FLOAT: if (cnt_zero) state_nxt = EPW_IDLE;
      EPW_FETCH: state_nxt = EPW_SETUP;
      EPW_SETUP: begin
        state_nxt = EPW_PULSE;
        cnt_nxt   = epw_cnt_t'(`EPW_WP_CYC - 1);
      end
      EPW_PULSE: if (cnt_zero) begin
        state_nxt = EPW_HOLD;
        cnt_nxt   = epw_cnt_t'(`EPW_HOLD_CYC - 1);
      end
      EPW_HOLD: if (cnt_zero) begin
        // next load follows at once, far inside the load spacing limit
        state_nxt = last_byte ? EPW_BL : EPW_FETCH;
        cnt_nxt   = epw_cnt_t'(`EPW_BL_CYC - 1);
      end
      EPW_BL: if (cnt_zero) begin
        state_nxt = poll_r ? EPW_DW : EPW_FIXED;
        cnt_nxt   = epw_cnt_t'(`EPW_DW_CYC - 1);
      end
      EPW_DW: if (cnt_zero) begin
        state_nxt = EPW_POLL;
        cnt_nxt   = epw_cnt_t'(`EPW_RD_CYC - 1);
      end
      EPW_POLL: if (cnt_zero) begin
        state_nxt = EPW_POLL_GAP;
        cnt_nxt   = epw_cnt_t'(`EPW_DF_CYC - 1);
      end
      EPW_POLL_GAP: if (cnt_zero) begin
        state_nxt = (ok_r || timed_out) ? EPW_IDLE : EPW_POLL;
        cnt_nxt   = epw_cnt_t'(`EPW_RD_CYC - 1);
      end
      EPW_FIXED: if (timed_out) state_nxt = EPW_IDLE;
      default: state_nxt = EPW_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge core_clk_i) begin
    din_s1_r <= data_bus_i;
    din_s2_r <= din_s1_r;
    rb_s1_r  <= rdy_busy_i;
    rb_s2_r  <= rb_s1_r;
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_r <= EPW_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ce_n_o           <= 1'b1;
      oe_n_o           <= 1'b1;
      we_n_o           <= 1'b1;
      data_bus_oe_n_o  <= 1'b1;
      // held low through reset so power ramps cannot program the array
      access_block_n_o <= 1'b0;
      req_ready_o      <= 1'b0;
    end else begin
      ce_n_o           <= ce_n_nxt;
      oe_n_o           <= oe_n_nxt;
      we_n_o           <= we_n_nxt;
      data_bus_oe_n_o  <= doe_n_nxt;
      access_block_n_o <= 1'b1;
      req_ready_o      <= (state_nxt == EPW_IDLE);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      idx_r <= '0; last_r <= '0; base_r <= '0; poll_r <= 1'b0;
      bit7_r <= 1'b0; ok_r <= 1'b0; prog_cnt_r <= '0;
      byte_address_o <= '0; data_bus_o <= '0; rd_data_o <= '0;
      rd_valid_o <= 1'b0; wr_done_o <= 1'b0; wr_timeout_o <= 1'b0;
    end else begin
      rd_valid_o <= (state_r == EPW_RD) && cnt_zero;
      wr_done_o  <= fin;
      if (take) begin
        base_r         <= req_addr_i;
        last_r         <= req_last_i;
        poll_r         <= poll_mode_i;
        idx_r          <= '0;
        byte_address_o <= req_addr_i;
      end
      if (state_r == EPW_RD && cnt_zero) rd_data_o <= din_s2_r;
      // bytes land at page base plus index, never leaving the page
      if (state_r == EPW_FETCH) byte_address_o <= {base_r[14:6], idx_r};
      if (state_r == EPW_SETUP) data_bus_o <= u_bif.rdata;
      if (state_r == EPW_PULSE) bit7_r <= data_bus_o[`EPW_POLL_BIT];
      if (state_r == EPW_HOLD && cnt_zero && !last_byte) idx_r <= idx_r + 1'b1;
      prog_cnt_r <= in_prog ? prog_cnt_r + 1'b1 : '0;
      if (state_r == EPW_POLL && cnt_zero) ok_r <= poll_ok;
      if (state_r == EPW_BL) ok_r <= 1'b0;
      if (fin) wr_timeout_o <= !ok_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int BLC_MAX = `EPW_BLC_MAX_CYC;
  localparam int DW_MIN  = `EPW_DW_CYC;
  epw_cnt_t gap_r;
  logic     first_r;

  always_ff @(posedge core_clk_i) begin
    if (reset_i || take) begin
      gap_r   <= '0;
      first_r <= 1'b1;
    end else if (!ce_n_nxt && !we_n_nxt && we_n_o) begin
      gap_r   <= '0;
      first_r <= 1'b0;
    end else begin
      gap_r   <= gap_r + 1'b1;
    end
  end

  property p_load_spacing;
    @(posedge core_clk_i) disable iff (reset_i)
      ($fell(we_n_o) && !$past(first_r)) |-> ($past(gap_r) < epw_cnt_t'(BLC_MAX));
  endproperty
  a_load_spacing: assert property (p_load_spacing)
    else $error("byte load started too late after previous strobe");

  property p_fixed_wait;
    @(posedge core_clk_i) disable iff (reset_i)
      ($rose(wr_done_o) && !poll_r) |-> ($past(prog_cnt_r) >= epw_cnt_t'(WC_CYC - 1));
  endproperty
  a_fixed_wait: assert property (p_fixed_wait)
    else $error("write finished before full cycle time");

  property p_poll_start;
    @(posedge core_clk_i) disable iff (reset_i)
      ($fell(oe_n_o) && poll_r && in_prog) |-> (prog_cnt_r >= epw_cnt_t'(DW_MIN));
  endproperty
  a_poll_start: assert property (p_poll_start)
    else $error("poll read began before write start time");

  property p_block_high;
    @(posedge core_clk_i) disable iff (reset_i)
      (!ce_n_o || !we_n_o || !oe_n_o) |-> access_block_n_o;
  endproperty
  a_block_high: assert property (p_block_high)
    else $error("access attempted while access block low");

  property p_block_reset;
    @(posedge core_clk_i) reset_i |=> (!access_block_n_o && ce_n_o && we_n_o);
  endproperty
  a_block_reset: assert property (p_block_reset)
    else $error("access block not low after reset");

  property p_we_width;
    @(posedge core_clk_i) disable iff (reset_i)
      $fell(we_n_o) |-> (!we_n_o && !data_bus_oe_n_o && !ce_n_o)[*5];
  endproperty
  a_we_width: assert property (p_we_width)
    else $error("write strobe shorter than minimum");

  property p_no_fight;
    @(posedge core_clk_i) disable iff (reset_i)
      !oe_n_o |-> (data_bus_oe_n_o && we_n_o);
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("host drives bus while device output enabled");

  c_read:    cover property (@(posedge core_clk_i) disable iff (reset_i) rd_valid_o);
  c_poll:    cover property (@(posedge core_clk_i) disable iff (reset_i)
                             wr_done_o && poll_r && !wr_timeout_o);
  c_fixed:   cover property (@(posedge core_clk_i) disable iff (reset_i)
                             wr_done_o && !poll_r);
  c_timeout: cover property (@(posedge core_clk_i) disable iff (reset_i)
                             wr_done_o && wr_timeout_o);
endmodule

// *** sim/epw_dev_model.sv ***
// behavioural page-write eeprom facing the host
module epw_dev_model (
  // pattern clock for a released bus
  input  wire logic               core_clk_i,
  // pins from host
  input  wire logic               access_block_n_i,
  input  wire logic               ce_n_i,
  input  wire logic               oe_n_i,
  input  wire logic               we_n_i,
  input  wire epw_pkg::epw_addr_t byte_address_i,
  input  wire epw_pkg::epw_byte_t host_data_i,
  input  wire logic               host_oe_n_i,
  input  wire integer             prog_ns_i,
  // pins to host
  output epw_pkg::epw_byte_t      data_bus_o,
  output logic                    rdy_busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import epw_pkg::*;
  epw_byte_t mem [0:32767];
  epw_addr_t qa[$];
  epw_byte_t qd[$];
  epw_addr_t lat_addr;
  epw_byte_t last_byte = 8'h00;
  epw_byte_t float_pat = 8'h00;
  logic      busy = 1'b0;
  longint    t_load = 0;
  int        page_loads = 0;
  logic      wr_act;
  logic      rd_act;
  ////////////////////////////////////////////////////////////////////////////
  assign wr_act = !ce_n_i && !we_n_i && oe_n_i && access_block_n_i;
  assign rd_act = !ce_n_i && !oe_n_i && we_n_i && access_block_n_i;
  assign rdy_busy_o = !busy; // pulled up when released
  initial for (int i = 0; i < 32768; i++) mem[i] = 8'(i * 7 + 3);
  always @(posedge core_clk_i) float_pat <= float_pat + 8'h3b;
  always @(posedge wr_act) lat_addr = byte_address_i;
  always @(negedge wr_act) begin
    if (access_block_n_i && qa.size() < 64) begin
      qa.push_back(lat_addr);
      qd.push_back(host_data_i);
      last_byte = host_data_i;
      t_load = $time;
      busy = 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // programming waits for a whole idle window; a late load restarts it
  always begin
    wait (busy);
    while ($time - t_load < 100000 || !(ce_n_i && we_n_i)) #10;
    #(prog_ns_i); // set by the bench; 30000 outlasts the 400-cycle write cycle ceiling
    foreach (qa[i]) mem[qa[i]] = qd[i];
    page_loads = qa.size();
    qa.delete();
    qd.delete();
    busy = 1'b0;
  end
  // a released bus shows a moving pattern so stale data cannot pass
  always_comb begin
    if (!host_oe_n_i) data_bus_o = host_data_i;
    else if (rd_act && busy) data_bus_o = {~last_byte[7], mem[byte_address_i][6:0]};
    else if (rd_act) data_bus_o = mem[byte_address_i];
    else data_bus_o = float_pat;
  end
endmodule

// *** sim/testbench.sv ***
// self-checking bench for the page write host
`include "epw_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import epw_pkg::*;
  logic      core_clk_i = 0, reset_i = 1, req_valid_i = 0, req_write_i = 0, poll_mode_i = 0;
  logic      buf_wr_i = 0, req_ready_o, rd_valid_o, wr_done_o, wr_timeout_o, data_bus_oe_n_o;
  logic      ce_n_o, oe_n_o, we_n_o, access_block_n_o, rdy_busy;
  epw_addr_t req_addr_i = 0, byte_address_o;
  epw_idx_t  req_last_i = 0, buf_idx_i = 0;
  epw_byte_t buf_data_i = 0, rd_data_o, data_bus_o, data_bus;
  epw_byte_t sh [0:32767];
  int        prog_ns = 3000, err_total = 0, checked = 0;
  integer    seed = 32'hb7f16aa7;
  ////////////////////////////////////////////////////////////////////////////
  epw_ctrl #(.WC_CYC(400)) u_epw_ctrl (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_last_i(req_last_i),
    .poll_mode_i(poll_mode_i), .req_ready_o(req_ready_o), .buf_wr_i(buf_wr_i),
    .buf_idx_i(buf_idx_i), .buf_data_i(buf_data_i), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .wr_done_o(wr_done_o), .wr_timeout_o(wr_timeout_o),
    .byte_address_o(byte_address_o), .data_bus_i(data_bus), .data_bus_o(data_bus_o),
    .data_bus_oe_n_o(data_bus_oe_n_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
    .access_block_n_o(access_block_n_o), .rdy_busy_i(rdy_busy));
  epw_dev_model u_epw_dev_model (
    .core_clk_i(core_clk_i), .access_block_n_i(access_block_n_o), .ce_n_i(ce_n_o),
    .oe_n_i(oe_n_o), .we_n_i(we_n_o), .byte_address_i(byte_address_o),
    .host_data_i(data_bus_o), .host_oe_n_i(data_bus_oe_n_o), .prog_ns_i(prog_ns),
    .data_bus_o(data_bus), .rdy_busy_o(rdy_busy));
  initial forever #25 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_ready();
    @(negedge core_clk_i);
    for (int i = 0; i < 5000 && req_ready_o !== 1'b1; i++) @(negedge core_clk_i);
  endtask
  task automatic do_read(input epw_addr_t a, input logic busy_exp = 1'b0);
    int n;
    wait_ready();
    req_valid_i = 1;
    req_write_i = 0;
    req_addr_i = a;
    @(negedge core_clk_i);
    req_valid_i = 0;
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1 n++;
    end while (rd_valid_o !== 1'b1 && n < 40);
    check(n, `EPW_RD_CYC, "read latency");
    if (busy_exp) check(rd_data_o[7], !sh[a][7], "busy bit seven");
    else check(rd_data_o, sh[a], "read data");
  endtask
  // a long prog_ns models a slow device; in poll mode expected timeout and ready level follow from it, fixed mode always flags a timeout
  task automatic do_write(input epw_addr_t base, input epw_idx_t last, input logic poll,
                          input logic exp_to);
    int n;
    wait_ready();
    for (int i = 0; i <= last; i++) begin
      buf_wr_i = 1;
      buf_idx_i = 6'(i);
      buf_data_i = 8'($random(seed));
      sh[{base[14:6], 6'(i)}] = buf_data_i;
      @(negedge core_clk_i);
    end
    buf_wr_i = 0;
    req_valid_i = 1;
    req_write_i = 1;
    req_addr_i = base;
    req_last_i = last;
    poll_mode_i = poll;
    @(negedge core_clk_i);
    req_valid_i = 0;
    n = 0;
    while (wr_done_o !== 1'b1 && n < 20000) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    check(wr_timeout_o, exp_to, "timeout flag");
    check(rdy_busy, !(poll && exp_to), "ready at done");
    // device still programming here, so a read shows the inverted last bit
    if (poll && exp_to) do_read({base[14:6], last}, 1'b1);
    for (int i = 0; i < 2000 && rdy_busy !== 1'b1; i++) @(negedge core_clk_i);
    check(u_epw_dev_model.page_loads, last + 1, "page length");
    for (int i = 0; i <= last; i++) do_read({base[14:6], 6'(i)});
    $display("test write poll=%0d last=%0d done", poll, last);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge core_clk_i);
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    for (int i = 0; i < 32768; i++) sh[i] = 8'(i * 7 + 3);
    repeat (16) @(negedge core_clk_i);
    reset_i = 0;
    @(negedge core_clk_i);
    check(access_block_n_o, 1, "block released");
    do_read(15'h0000);
    do_read(15'h7fff);
    repeat (8) do_read(15'($random(seed)));
    $display("test reads done");
    do_write(15'($random(seed)), 6'd63, 1, 0);
    do_write(15'h7fc0, 6'd0, 1, 0);
    do_write(15'($random(seed)), 6'($random(seed)), 0, 1);
    prog_ns = 30000;
    do_write(15'h0040, 6'd5, 1, 1);
    prog_ns = 3000;
    // reset in mid-read drops the strobes and blocks access
    wait_ready();
    req_valid_i = 1;
    req_write_i = 0;
    @(negedge core_clk_i);
    req_valid_i = 0;
    repeat (3) @(negedge core_clk_i);
    reset_i = 1;
    repeat (2) @(negedge core_clk_i);
    check(access_block_n_o, 0, "block in reset");
    check({ce_n_o, oe_n_o, we_n_o, req_ready_o}, 4'b1110, "strobes in reset");
    reset_i = 0;
    do_read(15'($random(seed)));
    $display("test mid-read reset done");
    summarize();
  end
endmodule
